// *** src/pcs_pkg.sv ***
// Package for the bus command and status register bank.
// Assumes a configuration access port that addresses 16-bit words by byte offset.
package pcs_pkg;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h06;
  localparam logic [15:0] CMD_RESET = 16'h00A0;
  localparam logic [15:0] CMD_WMASK = 16'h02A7;
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_SNOOP_BIT = 5;
  localparam int CMD_STEP_BIT = 7;
  localparam int CMD_B2B_BIT = 9;
  localparam int STAT_FB2B_BIT = 7;
  localparam int STAT_TMG_LO = 9;
  localparam int STAT_TMG_W = 2;
  localparam int XR_STRAP_BIT = 0;
  localparam logic [7:0] XR_ZERO = 8'h00;
  localparam int STAT_TABORT_BIT = 11;
  localparam int STAT_MABORT_BIT = 12;
  localparam int MISC_MEM_BIT = 1;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  // Device-select timing codes.
  typedef enum logic [1:0]
  {
    PCS_TMG_FAST = 2'b00,
    PCS_TMG_MEDIUM = 2'b01,
    PCS_TMG_SLOW = 2'b10,
    PCS_TMG_RSVD = 2'b11
  } pcs_timing_t;
  // Register access request.
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pcs_req_t;
  // Decoded controls handed to the bus logic.
  typedef struct packed
  {
    logic io_en;
    logic mem_en;
    logic master_en;
    logic snoop_en;
    logic step_en;
    logic b2b_en;
  } pcs_ctrl_t;
endpackage : pcs_pkg

// *** src/pcs_regs.sv ***
// Command and status configuration registers of the system bus interface.
// Assumes synchronous accesses on sys_clk_in and abort events as one-cycle pulses.
// The cycle description inputs are levels that stand for the whole bus cycle.
//
// Contract
// - Memory enable gates memory space decoding.
// - Memory accepted needs enable and legacy bit.
// - Bit 2 enables bus mastering, PCI only.
// - Snoop set completes palette writes without select.
// - Bit 7 enables address/data stepping, PCI only.
// - Bit 9 enables back-to-back master cycles, PCI only, with bit 2 set.
// - Command bits 15-10 reserved; resets to 00A0h.
// - Status writes of one clear bits.
// - Status bit 7 always reads one.
// - Timing bits from strap: low 01, high 10.
// - Timing codes fast, medium, slow, reserved.
// - Strap level readable in extended readback bit 0.
// - Target abort as master sets bit 11.
// - Master abort sets bit 12.
// - Status at bytes 7,6; bits 6-0 reserved.
// - Command bit 0 enables I/O space.
`timescale 1ns/1ps
module pcs_regs
  import pcs_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Register access port.
  input wire pcs_req_t req_in,
  output logic [15:0] rdata_out,
  // Straps and legacy inputs.
  input wire logic memory_data_strap_bit_in,
  input wire logic [7:0] legacy_misc_output_in,
  input wire logic pci_mode_in,
  // Bus cycle events and requests.
  input wire logic target_abort_in,
  input wire logic master_abort_in,
  input wire logic mem_cycle_in,
  input wire logic io_cycle_in,
  input wire logic palette_write_in,
  // Controls and status.
  output pcs_ctrl_t ctrl_out,
  output logic mem_claim_out,
  output logic io_claim_out,
  output logic local_bus_select_n_out,
  output pcs_timing_t devsel_timing_out,
  output logic [7:0] extended_strap_readback_out
);

  logic [15:0] bus_command;
  logic strap_done;
  logic strap_level;
  logic tabort;
  logic mabort;
  logic wr_cmd;
  logic wr_stat;
  logic [15:0] bus_status_word;
  logic rd_cmd;
  logic rd_stat;
  logic mem_hit;
  logic io_hit;

  // A memory cycle is taken only with the space enabled and the legacy gate open.
  function automatic logic mem_hit_f(input logic cycle, input logic [15:0] cmd, input logic [7:0] misc);
    mem_hit_f = cycle && cmd[CMD_MEM_BIT] && misc[MISC_MEM_BIT];
  endfunction : mem_hit_f

  // An I/O cycle with the space enabled is taken unless it is a palette write that the snoop bit lets pass on.
  function automatic logic io_hit_f(input logic cycle, input logic pal, input logic [15:0] cmd);
    io_hit_f = cycle && cmd[CMD_IO_BIT] && !(pal && cmd[CMD_SNOOP_BIT]);
  endfunction : io_hit_f

  // The strap picks medium or slow select timing; fast shows only as the devsel_timing_out reset value, the reserved code never.
  function automatic pcs_timing_t timing_f(input logic strap);
    timing_f = strap ? PCS_TMG_SLOW : PCS_TMG_MEDIUM;
  endfunction : timing_f

  // Word decode of the two register offsets.
  assign wr_cmd = req_in.wr && (req_in.addr == CMD_OFFSET);
  assign wr_stat = req_in.wr && (req_in.addr == STAT_OFFSET);
  assign rd_cmd = req_in.rd && (req_in.addr == CMD_OFFSET);
  assign rd_stat = req_in.rd && (req_in.addr == STAT_OFFSET);

  // Claim decisions shared by the claim flags and the local select.
  // Both use the live command word so a claim never lags a command write.
  assign mem_hit = mem_hit_f(mem_cycle_in, bus_command, legacy_misc_output_in);
  assign io_hit = io_hit_f(io_cycle_in, palette_write_in, bus_command);

  // Command register; only defined bits are writable.
  // Reserved bits are masked on the way in, so they always read zero.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      bus_command <= CMD_RESET;
    else if (wr_cmd)
      bus_command <= req_in.wdata & CMD_WMASK;
  end

  // Strap is caught on the first clock after reset release.
  // It is held from then on; only a new hardware reset samples it again.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      strap_done <= 1'b0;
      strap_level <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      strap_level <= memory_data_strap_bit_in;
    end
  end

  // Target-abort flag; a new event wins over a clear in the same cycle.
  // That way an abort is never lost to a clearing write that raced it.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tabort <= 1'b0;
    else if (target_abort_in)
      tabort <= 1'b1;
    else if (wr_stat && req_in.wdata[STAT_TABORT_BIT])
      tabort <= 1'b0;
  end

  // Master-abort flag, set and cleared in the same way.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mabort <= 1'b0;
    else if (master_abort_in)
      mabort <= 1'b1;
    else if (wr_stat && req_in.wdata[STAT_MABORT_BIT])
      mabort <= 1'b0;
  end

  // Status word assembly; reserved bits stay zero.
  // Fixed and strapped bits are built here, so a write can never reach them.
  always_comb
  begin
    bus_status_word = DATA_ZERO;
    bus_status_word[STAT_FB2B_BIT] = 1'b1;
    bus_status_word[STAT_TMG_LO +: STAT_TMG_W] = timing_f(strap_level);
    bus_status_word[STAT_TABORT_BIT] = tabort;
    bus_status_word[STAT_MABORT_BIT] = mabort;
  end

  // Registered read data; unmapped offsets read zero.
  // The data stands for one cycle and then falls back to zero.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= DATA_ZERO;
    else if (rd_cmd)
      rdata_out <= bus_command;
    else if (rd_stat)
      rdata_out <= bus_status_word;
    else
      rdata_out <= DATA_ZERO;
  end

  // Registered controls; the PCI-only bits stay off on the local bus.
  // They follow the command word one clock after a write.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ctrl_out <= '0;
    else
    begin
      ctrl_out.io_en <= bus_command[CMD_IO_BIT];
      ctrl_out.mem_en <= bus_command[CMD_MEM_BIT];
      ctrl_out.master_en <= bus_command[CMD_MASTER_BIT] && pci_mode_in;
      ctrl_out.snoop_en <= bus_command[CMD_SNOOP_BIT];
      ctrl_out.step_en <= bus_command[CMD_STEP_BIT] && pci_mode_in;
      ctrl_out.b2b_en <= bus_command[CMD_B2B_BIT] && bus_command[CMD_MASTER_BIT] && pci_mode_in;
    end
  end

  // Registered claim flags, one cycle after the cycle description.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mem_claim_out <= 1'b0;
      io_claim_out <= 1'b0;
    end
    else
    begin
      mem_claim_out <= mem_hit;
      io_claim_out <= io_hit;
    end
  end

  // Local select goes low for any claimed cycle.
  // A snooped palette write is not claimed, so it runs on to the ISA side.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      local_bus_select_n_out <= 1'b1;
    else
      local_bus_select_n_out <= !(mem_hit || io_hit);
  end

  // Strap-derived outputs follow the level caught after reset, one clock later.
  // Until then they show the reset values, then the low-strap values for one clock, so users wait two clocks.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      devsel_timing_out <= PCS_TMG_FAST;
      extended_strap_readback_out <= XR_ZERO;
    end
    else
    begin
      devsel_timing_out <= timing_f(strap_level);
      extended_strap_readback_out <= XR_ZERO;
      extended_strap_readback_out[XR_STRAP_BIT] <= strap_level;
    end
  end

endmodule : pcs_regs

// *** testbench/pcs_agent.sv ***
// Bus agent model: cycle and abort events.
// Bench sets one event; it lasts one clock.
`timescale 1ns/1ps
module pcs_agent
(
  input wire logic sys_clk_in,
  input wire logic [4:0] ev_in,
  output logic [4:0] ev_out
);
  // Events change just after the edge.
  always_ff @(posedge sys_clk_in)
  begin
    ev_out <= ev_in;
  end
endmodule : pcs_agent

// *** testbench/pcs_regs_chk.sv ***
// Checker of the command/status bank.
// Sees only the ports of pcs_regs.
`timescale 1ns/1ps
module pcs_regs_chk
  import pcs_pkg::*;
(
  input wire logic sys_clk_in, nrst_in, memory_data_strap_bit_in, pci_mode_in,
  input wire pcs_req_t req_in,
  input wire logic [15:0] rdata_out,
  input wire logic [7:0] legacy_misc_output_in, extended_strap_readback_out,
  input wire logic target_abort_in, master_abort_in, mem_cycle_in, io_cycle_in,
  input wire logic palette_write_in, mem_claim_out, io_claim_out, local_bus_select_n_out,
  input wire pcs_ctrl_t ctrl_out,
  input wire pcs_timing_t devsel_timing_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // Decodes used below.
  wire cw = req_in.wr && req_in.addr == CMD_OFFSET;
  wire sr = req_in.rd && req_in.addr == STAT_OFFSET;
  wire q = !req_in.wr;
  wire mok = mem_cycle_in && ctrl_out.mem_en && legacy_misc_output_in[MISC_MEM_BIT];
  wire [2:0] cb = {req_in.wdata[0], req_in.wdata[1], req_in.wdata[5]};
  wire mclr = req_in.wr && req_in.addr == STAT_OFFSET && req_in.wdata[STAT_MABORT_BIT];
  wire [1:0] tmg_exp = {extended_strap_readback_out[0], !extended_strap_readback_out[0]};
  wire pal_snp = io_cycle_in && palette_write_in && ctrl_out.snoop_en;
  sequence s_cw; cw ##1 !cw; endsequence
  sequence s_ta; target_abort_in ##1 q ##1 sr; endsequence
  sequence s_ma; master_abort_in ##1 q ##1 sr; endsequence
  sequence s_wc; mclr && !master_abort_in ##1 !master_abort_in ##1 sr; endsequence
  AST_CTRL: assert property (s_cw |=> {ctrl_out.io_en, ctrl_out.mem_en, ctrl_out.snoop_en} == $past(cb, 2))
    else $error("control bits wrong");
  AST_NOPCI: assert property (!pci_mode_in && !$past(pci_mode_in) |-> !ctrl_out.master_en && !ctrl_out.step_en)
    else $error("pci gating wrong");
  AST_FIX: assert property (sr |=> rdata_out[7] && rdata_out[6:0] == 7'h00 && rdata_out[15:13] == 3'h0)
    else $error("status fixed bits wrong");
  AST_TA: assert property (s_ta |=> rdata_out[STAT_TABORT_BIT])
    else $error("target abort lost");
  AST_MA: assert property (s_ma |=> rdata_out[STAT_MABORT_BIT])
    else $error("master abort lost");
  AST_W1C: assert property (s_wc |=> !rdata_out[STAT_MABORT_BIT])
    else $error("clear failed");
  AST_TMG: assert property ($past(nrst_in, 3) |-> devsel_timing_out == tmg_exp && $stable(devsel_timing_out))
    else $error("timing code wrong");
  AST_MEM: assert property (q && $past(q) |=> mem_claim_out == $past(mok))
    else $error("memory claim wrong");
  AST_SNP: assert property (q && $past(q) && pal_snp |=> !io_claim_out)
    else $error("snooped write claimed");
endmodule : pcs_regs_chk
bind pcs_regs pcs_regs_chk chk (.*);

// *** testbench/test_pcs_regs.sv ***
// Testbench of the command/status bank.
// Agent model gives cycles and aborts.
`timescale 1ns/1ps
module test_pcs_regs
  import pcs_pkg::*;
  ;
  logic sys_clk_in = 0, nrst_in = 0, strap = 1, pci = 0, mc, ic, sn;
  logic [7:0] misc = 8'h00, xr;
  logic [4:0] evc = 5'h00, ev;
  logic [15:0] rd;
  pcs_req_t req = '0;
  pcs_ctrl_t ctl;
  pcs_timing_t tmg;
  int error_cnt = 0, cmp_count = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  pcs_agent agent (.sys_clk_in, .ev_in(evc), .ev_out(ev));
  pcs_regs dut (.sys_clk_in, .nrst_in, .req_in(req), .rdata_out(rd), .memory_data_strap_bit_in(strap),
    .legacy_misc_output_in(misc), .pci_mode_in(pci), .target_abort_in(ev[1]), .master_abort_in(ev[0]),
    .mem_cycle_in(ev[2]), .io_cycle_in(ev[3]), .palette_write_in(ev[4]), .ctrl_out(ctl),
    .mem_claim_out(mc), .io_claim_out(ic), .local_bus_select_n_out(sn), .devsel_timing_out(tmg),
    .extended_strap_readback_out(xr));
  // Compare and count.
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  // One register access, held over one edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d = 16'h0000);
    @(posedge sys_clk_in) #1 req = '{w, !w, a, d};
    @(posedge sys_clk_in) #1 req = '0;
  endtask : acc
  // One bus event, then wait for the claim.
  task automatic cyc(input logic [4:0] v);
    @(posedge sys_clk_in) #1 evc = v;
    @(posedge sys_clk_in) #1 evc = 5'h00;
    @(posedge sys_clk_in) #1;
  endtask : cyc
  // Hardware reset with a strap level.
  task automatic rst(input logic s);
    nrst_in = 0;
    strap = s;
    repeat (20) @(posedge sys_clk_in);
    #1 nrst_in = 1;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : rst
  // Print counts and verdict.
  task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Main sequence.
  initial
  begin
    rst(1);
    chk("tmg", 16'(tmg), 16'h0002);
    chk("xr", 16'(xr), 16'h0001);
    acc(0, CMD_OFFSET);
    chk("cmd", rd, 16'h00a0);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h0480);
    acc(1, CMD_OFFSET, 16'hffff);
    acc(0, CMD_OFFSET);
    chk("cmd", rd, 16'h02a7);
    chk("ctl", 16'(ctl), 16'h0034);
    pci = 1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("ctl", 16'(ctl), 16'h003f);
    cyc(5'h04);
    chk("mem", 16'({mc, sn}), 16'h0001);
    misc = 8'h02;
    cyc(5'h04);
    chk("mem", 16'({mc, sn}), 16'h0002);
    cyc(5'h18);
    chk("pal", 16'({ic, sn}), 16'h0001);
    acc(1, CMD_OFFSET, 16'h0001);
    cyc(5'h18);
    chk("pal", 16'({ic, sn}), 16'h0002);
    cyc(5'h04);
    chk("mem", 16'({mc, sn}), 16'h0001);
    cyc(5'h02);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h0c80);
    cyc(5'h01);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h1c80);
    acc(1, STAT_OFFSET, 16'h0800);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h1480);
    acc(1, STAT_OFFSET, 16'hffff);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h0480);
    acc(0, 8'h08);
    chk("unm", rd, 16'h0000);
    rst(0);
    acc(0, STAT_OFFSET);
    chk("st", rd, 16'h0280);
    chk("xr", 16'(xr), 16'h0000);
    conclude();
  end
  // Watchdog against a hang.
  initial
  begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule : test_pcs_regs
